/* File: ctp_pkg.sv */
// Package for the cascaded 16-bit timer with PWM output.
// Assumes a single 200 MHz core clock drives every user of these constants.
package ctp_pkg;

    // Counting modes of the cascaded pair.
    typedef enum logic [1:0] {
        CTP_MODE_TIMER = 2'b00,
        CTP_MODE_EVENT = 2'b01,
        CTP_MODE_PWM   = 2'b10
    } ctp_mode_t;

    // Source clock selection codes.
    localparam logic [2:0] CTP_SRC_DIV11 = 3'h0;
    localparam logic [2:0] CTP_SRC_DIV7  = 3'h1;
    localparam logic [2:0] CTP_SRC_DIV5  = 3'h2;
    localparam logic [2:0] CTP_SRC_DIV3  = 3'h3;
    localparam logic [2:0] CTP_SRC_FS    = 3'h4;
    localparam logic [2:0] CTP_SRC_DIV1  = 3'h5;
    localparam logic [2:0] CTP_SRC_FC    = 3'h6;

    // Prescaler tap positions: fc/2^n taps bit n-1 of the divider.
    localparam int          CTP_TAP_DIV11   = 10;
    localparam int          CTP_TAP_DIV7    = 6;
    localparam int          CTP_TAP_DIV5    = 4;
    localparam int          CTP_TAP_DIV3    = 2;
    localparam int          CTP_TAP_FS_DIV3 = 2;
    localparam int          CTP_TAP_DIV1    = 0;
    localparam int          CTP_DIV_W       = 11;

    // Reset values.
    localparam logic [15:0] CTP_CNT_RST = 16'h0000;
    localparam logic [15:0] CTP_CMP_RST = 16'h0000;
    localparam logic [15:0] CTP_DUTY_RST = 16'h0000;
    localparam logic        CTP_FF_RST  = 1'b0;

    // Byte-write bus from the core.
    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic [7:0] data;
    } ctp_bytewr_t;

    // Control bits of the upper unit's control register.
    typedef struct packed {
        logic       ff_init;
        logic       run;
        ctp_mode_t  mode;
        logic [2:0] src;
        logic       div_sel;
        logic       slow_mode;
    } ctp_ctrl_t;

endpackage

/* File: ctp_tick_gen.sv */
// Prescaler that turns the core clock and a low-frequency tick into one
// counting tick for the cascaded timer.
// Assumes the high and low frequency clocks arrive as one-cycle enables.
`timescale 1ns/100ps
module ctp_tick_gen
    import ctp_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       fc_tick_i,
    input  wire logic       fs_tick_i,
    input  wire logic [2:0] src_i,
    input  wire logic       div_sel_i,
    input  wire logic       slow_mode_i,
    output logic            tick_o
);

    typedef struct packed {
        logic [CTP_DIV_W-1:0] fc_div;
        logic [2:0]           fs_div;
    } ctp_tick_state_t;

    ctp_tick_state_t st;
    ctp_tick_state_t next_st;
    logic [CTP_DIV_W-1:0] fc_rise;
    logic [2:0]           fs_rise;

    // Rising transitions of each divider bit mark one divided tick.
    always_comb
    begin
        next_st = st;
        if (fc_tick_i)
        begin
            next_st.fc_div = st.fc_div + 1'b1;
        end
        if (fs_tick_i)
        begin
            next_st.fs_div = st.fs_div + 1'b1;
        end
        fc_rise = next_st.fc_div & ~st.fc_div;
        fs_rise = next_st.fs_div & ~st.fs_div;
    end

    always_comb
    begin
        tick_o = 1'b0;
        if (slow_mode_i)
        begin
            // Only the low-frequency sources survive in slow and sleep modes.
            if (src_i == CTP_SRC_DIV11)
            begin
                tick_o = fs_rise[CTP_TAP_FS_DIV3];
            end
            else if (src_i == CTP_SRC_FS)
            begin
                tick_o = fs_tick_i;
            end
        end
        else
        begin
            unique case (src_i)
                CTP_SRC_DIV11: tick_o = div_sel_i ? fs_rise[CTP_TAP_FS_DIV3] : fc_rise[CTP_TAP_DIV11];
                CTP_SRC_DIV7:  tick_o = fc_rise[CTP_TAP_DIV7];
                CTP_SRC_DIV5:  tick_o = fc_rise[CTP_TAP_DIV5];
                CTP_SRC_DIV3:  tick_o = fc_rise[CTP_TAP_DIV3];
                CTP_SRC_FS:    tick_o = fs_tick_i;
                CTP_SRC_DIV1:  tick_o = fc_rise[CTP_TAP_DIV1];
                CTP_SRC_FC:    tick_o = fc_tick_i;
                default:       tick_o = 1'b0;
            endcase
        end
    end

    // The prescaler runs freely so that every source stays phase-stable.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule // ctp_tick_gen

/* File: ctp_cascade_timer.sv */
// Cascaded 16-bit timer, event counter and PWM generator.
// Assumes byte writes from the core, one core clock, and an async event pin.
`timescale 1ns/100ps
module ctp_cascade_timer
    import ctp_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        fc_tick_i,
    input  wire logic        fs_tick_i,
    input  wire logic        event_pin_i,
    input  wire ctp_ctrl_t   ctrl_i,
    input  wire logic        ctrl_wr_i,
    input  wire ctp_bytewr_t cmp_wr_i,
    input  wire ctp_bytewr_t duty_wr_i,
    output logic [15:0]      duty_rd_o,
    output logic [15:0]      count_o,
    output logic             cascade_match_irq_o,
    output logic             lower_unit_irq_o,
    output logic             output_flipflop_o,
    output logic             pwm_out_pin_o
);

    typedef struct packed {
        logic [2:0]  evt_sync;
        logic        evt_level;
        logic        run;
        logic        ff;
        logic [15:0] count;
        logic [15:0] compare;
        logic [15:0] duty_active;
        logic [15:0] duty_shadow;
        logic        irq;
    } ctp_state_t;

    ctp_state_t st;
    ctp_state_t next_st;
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       int_tick;
    logic       evt_fall;
    logic       step;

    // Reset is released through two flip-flops so removal is synchronous.
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ctp_tick_gen u_tick (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n),
        .fc_tick_i   (fc_tick_i),
        .fs_tick_i   (fs_tick_i),
        .src_i       (ctrl_i.src),
        .div_sel_i   (ctrl_i.div_sel),
        .slow_mode_i (ctrl_i.slow_mode),
        .tick_o      (int_tick)
    );

    // Waiting for two stages to agree costs a cycle, but it rejects a pin caught mid-swing.
    // falling edge once second and third stages agree
    assign evt_fall = (st.evt_sync[2:1] == 2'b00) && st.evt_level;

    // Next-state logic for the whole timer; the register process below only copies it.
    always_comb
    begin
        next_st          = st;
        next_st.irq      = 1'b0;
        next_st.evt_sync = {st.evt_sync[1:0], event_pin_i};
        if (st.evt_sync[2] == st.evt_sync[1])
        begin
            next_st.evt_level = st.evt_sync[2];
        end
        // event mode steps on the pin instead
        step = st.run && ((ctrl_i.mode == CTP_MODE_EVENT) ? evt_fall : int_tick);

        // run bit and flip-flop initial value
        // init only applies while stopped, so a stop keeps the level
        if (ctrl_wr_i)
        begin
            next_st.run = ctrl_i.run;
            if (!st.run && !ctrl_i.run)
            begin
                // software loads the flip-flop initial value
                next_st.ff = ctrl_i.ff_init;
            end
        end

        // compare writes land immediately, no buffering
        if (cmp_wr_i.wr_low)
        begin
            next_st.compare[7:0] = cmp_wr_i.data;
        end
        if (cmp_wr_i.wr_high)
        begin
            next_st.compare[15:8] = cmp_wr_i.data;
        end

        // writes go to the shadow; stopped timer copies at once
        if (duty_wr_i.wr_low)
        begin
            next_st.duty_shadow[7:0] = duty_wr_i.data;
        end
        if (duty_wr_i.wr_high)
        begin
            next_st.duty_shadow[15:8] = duty_wr_i.data;
        end
        if (!st.run)
        begin
            next_st.duty_active = next_st.duty_shadow;
        end

        if (step)
        begin
            unique case (ctrl_i.mode)
                CTP_MODE_PWM:
                begin
                    if (st.count == 16'hFFFF)
                    begin
                        next_st.ff    = ~st.ff;
                        next_st.count = CTP_CNT_RST;
                        next_st.irq   = 1'b1;
                        // shadow moves to active on the interrupt
                        next_st.duty_active = next_st.duty_shadow;
                    end
                    else
                    begin
                        next_st.count = st.count + 16'h0001;
                        if (next_st.count == st.duty_active)
                        begin
                            next_st.ff = ~st.ff;
                        end
                    end
                end
                default:
                begin
                    // event match interrupts and clears
                    // The sum wraps at the top, so a compare of zero gives the full 65536-tick period.
                    if (st.count + 16'h0001 == st.compare)
                    begin
                        next_st.count = CTP_CNT_RST;
                        next_st.irq   = 1'b1;
                    end
                    else
                    begin
                        next_st.count = st.count + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Single state register for the whole timer.
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st             <= '0;
            st.evt_sync    <= 3'b111;
            st.evt_level   <= 1'b1;
            st.count       <= CTP_CNT_RST;
            st.compare     <= CTP_CMP_RST;
            st.duty_active <= CTP_DUTY_RST;
            st.duty_shadow <= CTP_DUTY_RST;
            st.ff          <= CTP_FF_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs come from the state register, through at most an inverter, or are tied low, so none of them can glitch.
    // read-back shows the active duty, not the pending one
    assign duty_rd_o           = st.duty_active;
    assign count_o             = st.count;
    assign cascade_match_irq_o = st.irq;
    assign lower_unit_irq_o    = 1'b0;
    assign output_flipflop_o   = st.ff;
    // pin is the inverse of the flip-flop
    assign pwm_out_pin_o       = ~st.ff;

endmodule // ctp_cascade_timer

/* File: ctp_checker.sv */
// Port checker for the cascaded timer.
// Assumes it is bound to ctp_cascade_timer below.
`timescale 1ns/100ps
module ctp_checker
    import ctp_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire ctp_ctrl_t   ctrl_i,
    input  wire logic        ctrl_wr_i,
    input  wire ctp_bytewr_t duty_wr_i,
    input  wire logic [15:0] duty_rd_o,
    input  wire logic [15:0] count_o,
    input  wire logic        cascade_match_irq_o,
    input  wire logic        lower_unit_irq_o,
    input  wire logic        output_flipflop_o,
    input  wire logic        pwm_out_pin_o
);
    logic run_q;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // Mirror of the run bit, which the design keeps inside.
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            run_q <= 1'b0;
        else if (ctrl_wr_i)
            run_q <= ctrl_i.run;
    end

    a_pin_inverse: assert property (pwm_out_pin_o == !output_flipflop_o)
        else $error("pin not inverse of flip-flop");
    a_lower_quiet: assert property (!lower_unit_irq_o)
        else $error("lower unit interrupt raised");
    a_irq_clears: assert property (cascade_match_irq_o |-> count_o == 16'h0000)
        else $error("interrupt without cleared count");
    a_clear_has_irq: assert property ($changed(count_o) && count_o == 16'h0000 |-> cascade_match_irq_o)
        else $error("count cleared without interrupt");
    a_count_steps: assert property ($changed(count_o) |-> count_o == 16'h0000 || count_o == $past(count_o) + 16'h0001)
        else $error("count moved by other than one");
    a_ff_cause: assert property ($changed(output_flipflop_o) && !$past(ctrl_wr_i)
        |-> cascade_match_irq_o || count_o == duty_rd_o)
        else $error("flip-flop toggled without cause");
    a_stopped_holds: assert property (!run_q && !ctrl_wr_i |=> $stable(output_flipflop_o) && $stable(count_o))
        else $error("stopped timer changed state");
    a_duty_buffered: assert property ($changed(duty_rd_o) && run_q && $past(run_q) |-> cascade_match_irq_o)
        else $error("active duty changed while running");
    a_duty_direct: assert property (duty_wr_i.wr_low && !run_q |=> duty_rd_o[7:0] == $past(duty_wr_i.data))
        else $error("stopped duty write not immediate");
endmodule // ctp_checker

bind ctp_cascade_timer ctp_checker i_chk (.core_clk_i, .nrst_i, .ctrl_i, .ctrl_wr_i, .duty_wr_i, .duty_rd_o,
    .count_o, .cascade_match_irq_o, .lower_unit_irq_o, .output_flipflop_o, .pwm_out_pin_o);

/* File: ctp_event_src.sv */
// External event source for the counter's event pin.
// Assumes the bench calls send_falls from just after a clock edge.
`timescale 1ns/100ps
module ctp_event_src
#(
    parameter int HOLD_CYC = 4
)
(
    input  wire logic clk_i,
    output logic      event_pin_o
);
    // The pin idles high, so a burst always begins with a falling edge.
    initial event_pin_o = 1'b1;

    task automatic send_falls(input int n);
        repeat (n)
        begin
            repeat (HOLD_CYC) @(posedge clk_i);
            #1 event_pin_o = 1'b0;
            repeat (HOLD_CYC) @(posedge clk_i);
            #1 event_pin_o = 1'b1;
        end
    endtask
endmodule // ctp_event_src

/* File: tb_ctp_cascade_timer.sv */
// Self-checking bench for the cascaded timer.
// Assumes the package, design, checker and event source compile first.
`timescale 1ns/100ps
module tb_ctp_cascade_timer
    import ctp_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [1:0]  fs_cnt = 2'd0;
    logic        fs_tick;
    logic        evt;
    ctp_ctrl_t   ctrl = '0;
    logic        ctrl_wr = 1'b0;
    ctp_bytewr_t cmp_wr = '0;
    ctp_bytewr_t duty_wr = '0;
    logic [15:0] duty_rd;
    logic [15:0] count;
    logic        irq;
    logic        low_irq;
    logic        ff;
    logic        pin;
    int          n_errors = 0;
    int          num_checks = 0;

    // Core clock, and a slow tick at a quarter of its rate.
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) fs_cnt <= #1 fs_cnt + 2'd1;
    assign fs_tick = (fs_cnt == 2'd3);

    ctp_cascade_timer i_dut (.core_clk_i(core_clk), .nrst_i(nrst), .fc_tick_i(1'b1), .fs_tick_i(fs_tick),
        .event_pin_i(evt), .ctrl_i(ctrl), .ctrl_wr_i(ctrl_wr), .cmp_wr_i(cmp_wr), .duty_wr_i(duty_wr),
        .duty_rd_o(duty_rd), .count_o(count), .cascade_match_irq_o(irq), .lower_unit_irq_o(low_irq),
        .output_flipflop_o(ff), .pwm_out_pin_o(pin));
    ctp_event_src i_evt (.clk_i(core_clk), .event_pin_o(evt));

    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Inputs always move 1 ns after an edge, never on it.
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One idle cycle after each write, so that back-to-back calls never lower and raise the strobe at once.
    task automatic wr_ctrl(input logic run, input logic ffi);
        ctrl.run = run;
        ctrl.ff_init = ffi;
        ctrl_wr = 1'b1;
        step(1);
        ctrl_wr = 1'b0;
        step(1);
    endtask

    // low byte first, then high byte, never one alone.
    task automatic wr16(input bit duty, input logic [15:0] v);
        ctp_bytewr_t w;
        for (int i = 0; i < 2; i++)
        begin
            w = '{i == 0, i == 1, v[8*i +: 8]};
            if (duty)
                duty_wr = w;
            else
                cmp_wr = w;
            step(1);
        end
        duty_wr = '0;
        cmp_wr = '0;
    endtask

    // Bounded wait for the interrupt or for a count value.
    task automatic wait_sig(input bit use_irq, input logic [15:0] c, output int n);
        n = 0;
        while (use_irq ? irq !== 1'b1 : count !== c)
        begin
            step(1);
            n++;
            if (n > 70000)
            begin
                n_errors++;
                end_sim();
            end
        end
    endtask

    task automatic t_reset();
        chk(count, 16'h0000);
        chk(duty_rd, 16'h0000);
        chk(16'({ff, pin, irq, low_irq}), 16'h0004);
    endtask

    task automatic t_event();
        ctrl.mode = CTP_MODE_EVENT;
        wr16(1'b0, 16'h0003);
        wr_ctrl(1'b1, 1'b0);
        i_evt.send_falls(2);
        step(8);
        chk(count, 16'h0002);
        i_evt.send_falls(1);
        step(8);
        chk(count, 16'h0000);
        i_evt.send_falls(1);
        step(8);
        chk(count, 16'h0001);
        wr_ctrl(1'b0, 1'b0);
    endtask

    // Interrupt spacing for compare 2 across the DIV11, DIV7, DIV5 and DIV3 fc taps and the fs/8 path of DIV11, normal and slow.
    task automatic t_timer();
        int per[6] = '{4096, 256, 64, 16, 64, 64};
        int n;
        ctrl.mode = CTP_MODE_TIMER;
        wr16(1'b0, 16'h0002);
        for (int i = 0; i < 6; i++)
        begin
            ctrl.src = (i < 4) ? 3'(i) : CTP_SRC_DIV11;
            ctrl.div_sel = (i == 4);
            ctrl.slow_mode = (i == 5);
            wr_ctrl(1'b1, 1'b0);
            wait_sig(1'b1, 16'h0, n);
            step(1);
            wait_sig(1'b1, 16'h0, n);
            chk(16'(n + 1), 16'(per[i]));
            wr_ctrl(1'b0, 1'b0);
        end
    endtask

    task automatic t_pwm();
        int n;
        ctrl.mode = CTP_MODE_PWM;
        ctrl.src = CTP_SRC_FC;
        ctrl.div_sel = 1'b0;
        ctrl.slow_mode = 1'b0;
        wr16(1'b1, 16'h0100);
        chk(duty_rd, 16'h0100);
        wr_ctrl(1'b1, 1'b0);
        wr16(1'b1, 16'h0200);
        chk(duty_rd, 16'h0100);
        wait_sig(1'b0, 16'h0101, n);
        chk(16'(ff), 16'h0001);
        wait_sig(1'b1, 16'h0, n);
        chk(16'(ff), 16'h0000);
        chk(duty_rd, 16'h0200);
        wr16(1'b1, 16'h0300);
        chk(duty_rd, 16'h0200);
        wr_ctrl(1'b0, 1'b1);
        chk(16'(ff), 16'h0000);
        chk(duty_rd, 16'h0300);
        wr_ctrl(1'b0, 1'b1);
        // port latch taken as set; the pin is watched directly.
        chk(16'(pin), 16'h0000);
    endtask

    // Cycles between two count steps for the extra PWM sources; the bench's fs tick comes every 4 cycles.
    task automatic t_pwm_src();
        logic [2:0]  srcs[3] = '{CTP_SRC_FS, CTP_SRC_DIV1, CTP_SRC_FS};
        int          per[3] = '{4, 2, 4};
        int          n;
        logic [15:0] c;
        ctrl.mode = CTP_MODE_PWM;
        for (int i = 0; i < 3; i++)
        begin
            ctrl.src = srcs[i];
            ctrl.slow_mode = (i == 2);
            wr_ctrl(1'b1, 1'b0);
            c = count + 16'h0001;
            wait_sig(1'b0, c, n);
            wait_sig(1'b0, c + 16'h0001, n);
            chk(16'(n), 16'(per[i]));
            wr_ctrl(1'b0, 1'b0);
        end
    endtask

    // A reset in mid-run must clear the flip-flop that the PWM scenario left set.
    task automatic t_rst_mid();
        chk(16'(ff), 16'h0001);
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        step(3);
        t_reset();
    endtask

    // Reset for 12 cycles, then each scenario in turn.
    initial
    begin
        repeat (12) @(posedge core_clk);
        #1 nrst = 1'b1;
        step(3);
        t_reset();
        t_event();
        t_timer();
        t_pwm();
        t_pwm_src();
        t_rst_mid();
        end_sim();
    end
endmodule // tb_ctp_cascade_timer
